// [verilog/cvd_precharge_guard_sequencer.sv]
// capacitive divider precharge, acquisition and guard ring sequencer with avalon register slave
`timescale 1ns/1ps
`default_nettype none
module cvd_precharge_guard_sequencer
  import cvd_seq_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // avalon-mm slave
  input wire logic [cvd_seq_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // converter side
  input wire logic rc_osc_tick,
  input wire logic special_trigger,
  input wire logic restart_req,
  input wire logic threshold_event,
  input wire logic [cvd_seq_pkg::RES_W-1:0] adc_data,
  // analog switch, pin override and guard controls, conversion done and compute strobe
  output logic hold_to_supply,
  output logic hold_to_ground,
  output logic outer_path_connect,
  output logic pin_drive_out,
  output logic pin_drive_oe,
  output logic extra_cap_connect,
  output logic [7:0] extra_cap_sel,
  output logic guard_out_a,
  output logic guard_out_b,
  output logic conversion_done,
  output logic compute_strobe
);
  import cvd_seq_pkg::*;

  // ****************************************
  // registers
  // ****************************************
  logic [7:0] ctrl0_reg, ctrl1_reg, pre_reg, acq_reg, cap_reg, clkdiv_reg, misc_reg;
  logic [RES_W-1:0] result_reg, previous_result_reg;
  logic conversion_interrupt_flag_reg, threshold_flag_reg;
  logic ack_reg;
  logic rc_s1_reg, rc_s2_reg, rc_s3_reg;
  logic [7:0] div_cnt_reg;
  logic tick;
  stage_t stage_reg;
  logic [7:0] count_reg;
  logic second_reg;
  logic [RES_W-1:0] shift_reg;
  logic go_set, go_sw_clr, go_hw_clr, go_hw_set, start, abort, conv_end;
  logic inv_now, pol_eff, guard_polarity_eff;

  wire enable = ctrl0_reg[B_ON];
  wire go_bit = ctrl0_reg[B_GO];
  wire wr_acc = write & ~ack_reg;
  wire wr0 = wr_acc & (address == IDX_CTRL0) & byteenable[0];

  // ****************************************
  // bus slave: one wait state on every access
  // ****************************************
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (read | write) & ~ack_reg;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= ~((read | write) & ~ack_reg);
    end
  end

  // right or left justified result view
  function automatic logic [15:0] justify(input logic [RES_W-1:0] v, input logic right);
    justify = right ? {6'h00, v} : {v, 6'h00};
  endfunction

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      readdata <= 32'h0000_0000;
    end else if (read & ~ack_reg) begin
      case (address)
        IDX_CTRL0: readdata <= {24'h000000, ctrl0_reg};
        IDX_CTRL1: readdata <= {24'h000000, ctrl1_reg};
        IDX_PRE: readdata <= {24'h000000, pre_reg};
        IDX_ACQ: readdata <= {24'h000000, acq_reg};
        IDX_CAP: readdata <= {24'h000000, cap_reg};
        IDX_CLKDIV: readdata <= {24'h000000, clkdiv_reg};
        IDX_MISC: readdata <= {24'h000000, misc_reg};
        IDX_RESULT: readdata <= {justify(previous_result_reg, ctrl0_reg[B_JUST]),
                                 justify(result_reg, ctrl0_reg[B_JUST])};
        IDX_STATUS: readdata <= {24'h000000, 1'b0, stage_reg, second_reg,
                                 1'b0, threshold_flag_reg, conversion_interrupt_flag_reg};
        default: readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // plain configuration registers
  // ****************************************
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl1_reg <= RESET_BYTE;
      pre_reg <= RESET_BYTE;
      acq_reg <= RESET_BYTE;
      cap_reg <= RESET_BYTE;
      clkdiv_reg <= RESET_BYTE;
      misc_reg <= RESET_BYTE;
    end else if (wr_acc & byteenable[0]) begin
      case (address)
        IDX_CTRL1: ctrl1_reg <= writedata[7:0] & CTRL1_MASK;
        IDX_PRE: pre_reg <= writedata[7:0];
        IDX_ACQ: acq_reg <= writedata[7:0];
        IDX_CAP: cap_reg <= writedata[7:0];
        IDX_CLKDIV: clkdiv_reg <= writedata[7:0];
        IDX_MISC: misc_reg <= {7'h00, writedata[B_SOI]};
        default: ;
      endcase
    end
  end

  // ****************************************
  // start bit control
  // ****************************************
  assign go_set = (wr0 & writedata[B_GO] & writedata[B_ON]) | (enable & (special_trigger | restart_req));
  assign go_sw_clr = wr0 & ~writedata[B_GO];
  // retrigger stops on threshold only when stop-on-interrupt is set
  assign go_hw_set = conv_end & ctrl0_reg[B_AUTO_RETRIGGER_ENABLE] & ~(misc_reg[B_SOI] & (threshold_flag_reg | threshold_event));
  assign go_hw_clr = conv_end & ~go_hw_set;
  assign abort = go_bit & go_sw_clr & (stage_reg != ST_IDLE);

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl0_reg <= RESET_BYTE;
    end else begin
      if (wr0) begin
        ctrl0_reg[7:1] <= writedata[7:1] & CTRL0_MASK[7:1];
      end
      // software set wins over a hardware clear in the same cycle
      if (go_set | go_hw_set) begin
        ctrl0_reg[B_GO] <= 1'b1;
      end else if (go_sw_clr | go_hw_clr | ~enable) begin
        ctrl0_reg[B_GO] <= 1'b0;
      end
    end
  end

  // ****************************************
  // converter clock enable
  // ****************************************
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rc_s1_reg <= 1'b0;
      rc_s2_reg <= 1'b0;
      rc_s3_reg <= 1'b0;
    end else begin
      rc_s1_reg <= rc_osc_tick;
      rc_s2_reg <= rc_s1_reg;
      rc_s3_reg <= rc_s2_reg;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      div_cnt_reg <= RESET_BYTE;
    end else if (div_cnt_reg >= clkdiv_reg) begin
      div_cnt_reg <= RESET_BYTE;
    end else begin
      div_cnt_reg <= div_cnt_reg + 8'h01;
    end
  end

  // oscillator edges reach this domain through the two-flop synchroniser
  always_comb begin
    if (ctrl0_reg[B_CSEL]) begin
      tick = rc_s2_reg & ~rc_s3_reg;
    end else begin
      tick = (div_cnt_reg >= clkdiv_reg);
    end
  end

  // ****************************************
  // stage sequencer
  // ****************************************
  assign start = go_bit & enable & (stage_reg == ST_IDLE);
  assign conv_end = (stage_reg == ST_CONV) & tick & (count_reg == 8'h01);
  assign inv_now = ctrl1_reg[B_DOUBLE_SAMPLE_ENABLE] & ctrl1_reg[B_INVERTED_PRECHARGE_ENABLE] & second_reg;
  assign pol_eff = ctrl1_reg[B_PRECHARGE_POLARITY] ^ inv_now;
  assign guard_polarity_eff = ctrl1_reg[B_GUARD_POLARITY] ^ inv_now;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      stage_reg <= ST_IDLE;
      count_reg <= RESET_BYTE;
    end else if (abort | ~enable) begin
      stage_reg <= ST_IDLE;
      count_reg <= RESET_BYTE;
    end else begin
      case (stage_reg)
        ST_IDLE: begin
          if (start) begin
            if (pre_reg != RESET_BYTE) begin
              stage_reg <= ST_PRE;
              count_reg <= pre_reg;
            end else if (acq_reg != RESET_BYTE) begin
              stage_reg <= ST_ACQ;
              count_reg <= acq_reg;
            end else begin
              stage_reg <= ST_CONV;
              count_reg <= {4'h0, CONV_LEN};
            end
          end
        end
        ST_PRE: begin
          if (tick) begin
            if (count_reg == 8'h01) begin
              stage_reg <= ST_ACQ;
              count_reg <= (acq_reg == RESET_BYTE) ? MAX_ACQ : acq_reg;
            end else begin
              count_reg <= count_reg - 8'h01;
            end
          end
        end
        ST_ACQ: begin
          if (tick) begin
            if (count_reg == 8'h01) begin
              stage_reg <= ST_CONV;
              count_reg <= {4'h0, CONV_LEN};
            end else begin
              count_reg <= count_reg - 8'h01;
            end
          end
        end
        ST_CONV: begin
          if (tick) begin
            if (count_reg == 8'h01) begin
              stage_reg <= ST_IDLE;
            end else begin
              count_reg <= count_reg - 8'h01;
            end
          end
        end
        default: stage_reg <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // analog switch and pin override outputs
  // ****************************************
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      hold_to_supply <= 1'b0;
      hold_to_ground <= 1'b0;
      outer_path_connect <= 1'b0;
      pin_drive_out <= 1'b0;
      pin_drive_oe <= 1'b0;
      extra_cap_connect <= 1'b0;
      extra_cap_sel <= RESET_BYTE;
    end else begin
      hold_to_supply <= (stage_reg == ST_PRE) & ~pol_eff;
      hold_to_ground <= (stage_reg == ST_PRE) & pol_eff;
      outer_path_connect <= (stage_reg == ST_ACQ) | (stage_reg == ST_CONV);
      // override wins over the pin's own direction, latch and guard setting
      pin_drive_oe <= (stage_reg == ST_PRE) & ~ctrl1_reg[B_HOLD_CAP_ONLY_PRECHARGE];
      pin_drive_out <= pol_eff;
      extra_cap_connect <= (stage_reg != ST_CONV) & (cap_reg != RESET_BYTE);
      extra_cap_sel <= cap_reg;
    end
  end

  // ****************************************
  // guard ring outputs
  // ****************************************
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      guard_out_a <= 1'b0;
      guard_out_b <= 1'b0;
    end else if (stage_reg == ST_PRE) begin
      guard_out_a <= guard_polarity_eff;
      guard_out_b <= guard_polarity_eff;
    end else if (stage_reg == ST_ACQ) begin
      guard_out_a <= ~guard_polarity_eff;
      guard_out_b <= guard_polarity_eff;
    end
  end

  // ****************************************
  // conversion result, pairing and flags
  // ****************************************
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      shift_reg <= '0;
    end else if (stage_reg == ST_CONV && tick) begin
      shift_reg <= adc_data;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      result_reg <= '0;
      previous_result_reg <= '0;
      second_reg <= 1'b0;
      conversion_done <= 1'b0;
      compute_strobe <= 1'b0;
    end else begin
      conversion_done <= conv_end;
      compute_strobe <= conv_end & (~ctrl1_reg[B_DOUBLE_SAMPLE_ENABLE] | second_reg);
      if (abort) begin
        result_reg <= shift_reg;
        second_reg <= 1'b0;
      end else if (conv_end) begin
        previous_result_reg <= result_reg;
        result_reg <= adc_data;
        second_reg <= ctrl1_reg[B_DOUBLE_SAMPLE_ENABLE] & ~second_reg;
      end else if (~ctrl1_reg[B_DOUBLE_SAMPLE_ENABLE]) begin
        second_reg <= 1'b0;
      end
    end
  end

  // sticky flags, cleared by writing one; a new event wins over the clear
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      conversion_interrupt_flag_reg <= 1'b0;
      threshold_flag_reg <= 1'b0;
    end else begin
      if (conv_end) begin
        conversion_interrupt_flag_reg <= 1'b1;
      end else if (wr_acc & (address == IDX_STATUS) & byteenable[0] & writedata[0]) begin
        conversion_interrupt_flag_reg <= 1'b0;
      end
      if (threshold_event) begin
        threshold_flag_reg <= 1'b1;
      end else if (wr_acc & (address == IDX_STATUS) & byteenable[0] & writedata[1]) begin
        threshold_flag_reg <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// [verilog/cvd_seq_pkg.sv]
// constants, register map and types for the capacitive divider sequencer
package cvd_seq_pkg;
  localparam int ADDR_W = 4;
  // word indices (byte address = 4 * index); control 0/1 keep their printed offsets
  localparam logic [15:0] CTRL0_OFFSET = 16'h1D26;
  localparam logic [15:0] CTRL1_OFFSET = 16'h1D27;
  localparam logic [ADDR_W-1:0] IDX_CTRL0 = 4'h0;
  localparam logic [ADDR_W-1:0] IDX_CTRL1 = 4'h1;
  localparam logic [ADDR_W-1:0] IDX_PRE = 4'h2;
  localparam logic [ADDR_W-1:0] IDX_ACQ = 4'h3;
  localparam logic [ADDR_W-1:0] IDX_CAP = 4'h4;
  localparam logic [ADDR_W-1:0] IDX_CLKDIV = 4'h5;
  localparam logic [ADDR_W-1:0] IDX_MISC = 4'h6;
  localparam logic [ADDR_W-1:0] IDX_RESULT = 4'h7;
  localparam logic [ADDR_W-1:0] IDX_STATUS = 4'h8;
  // control 0 fields
  localparam int B_GO = 0;
  localparam int B_JUST = 2;
  localparam int B_CSEL = 4;
  localparam int B_AUTO_RETRIGGER_ENABLE = 6;
  localparam int B_ON = 7;
  localparam logic [7:0] CTRL0_MASK = 8'hD5;
  // control 1 fields
  localparam int B_DOUBLE_SAMPLE_ENABLE = 0;
  localparam int B_HOLD_CAP_ONLY_PRECHARGE = 1;
  localparam int B_GUARD_POLARITY = 5;
  localparam int B_INVERTED_PRECHARGE_ENABLE = 6;
  localparam int B_PRECHARGE_POLARITY = 7;
  localparam logic [7:0] CTRL1_MASK = 8'hE3;
  // misc control: stop-on-interrupt
  localparam int B_SOI = 0;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] MAX_ACQ = 8'hFF;
  localparam int CONV_CYCLES = 11;
  localparam logic [3:0] CONV_LEN = 4'(CONV_CYCLES);
  localparam int RES_W = 10;
  typedef enum logic [2:0] {ST_IDLE, ST_PRE, ST_ACQ, ST_WAIT, ST_CONV} stage_t;
endpackage

// [test/sensor_model.sv]
// behavioural model of the capacitive sensor node and its sample path
`timescale 1ns/1ps
`default_nettype none
module sensor_model (
  // design side
  input wire logic clock,
  input wire logic pin_drive_out,
  input wire logic pin_drive_oe,
  input wire logic hold_to_supply,
  input wire logic hold_to_ground,
  input wire logic outer_path_connect,
  // converter sample
  output logic [9:0] adc_data
);
  // ****************
  // charge sharing
  // ****************
  logic node_q = 1'b0;
  logic hold_q = 1'b0;
  logic [9:0] last_q = 10'h000;
  logic [9:0] mix;
  // sensor weighs three times the hold cap, so pin and cap levels both show in the sample
  assign mix = (hold_q ? 10'h0FF : 10'h000) + (node_q ? 10'h2FF : 10'h000);
  always @(posedge clock) begin
    if (pin_drive_oe) node_q <= pin_drive_out;
    if (hold_to_supply || hold_to_ground) hold_q <= hold_to_supply;
    if (outer_path_connect) last_q <= mix;
  end
  // a released path floats: show the inverse rather than a stale value
  assign adc_data = outer_path_connect ? mix : ~last_q;
endmodule
`default_nettype wire

// [test/cvd_seq_monitor.sv]
// concurrent checks on the sequencer ports
`timescale 1ns/1ps
`default_nettype none
module cvd_seq_monitor (
  // watched ports
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input wire logic hold_to_supply,
  input wire logic hold_to_ground,
  input wire logic outer_path_connect,
  input wire logic pin_drive_out,
  input wire logic pin_drive_oe,
  input wire logic extra_cap_connect,
  input wire logic guard_out_a,
  input wire logic guard_out_b,
  input wire logic conversion_done,
  input wire logic compute_strobe
);
  // ****************
  // properties
  // ****************
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_pre_end;
    $fell(hold_to_supply || hold_to_ground);
  endsequence
  sequence s_guards_split;
    ##[0:3] guard_out_a != guard_out_b;
  endsequence
  a_bus_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer late");
  a_hold_isolated: assert property ((hold_to_supply || hold_to_ground) |->
    !outer_path_connect && !(hold_to_supply && hold_to_ground)) else $error("hold tie wrong");
  a_pin_opposite: assert property (pin_drive_oe |->
    pin_drive_out == hold_to_ground && !outer_path_connect) else $error("pin level wrong");
  a_acq_follows: assert property (s_pre_end |->
    ##[0:2] outer_path_connect && !pin_drive_oe) else $error("no acquisition");
  a_guard_split: assert property (s_pre_end |-> s_guards_split)
    else $error("guard a not inverted");
  a_guard_equal: assert property ((hold_to_supply || hold_to_ground) &&
    $past(hold_to_supply || hold_to_ground) |-> guard_out_a == guard_out_b) else $error("guards differ");
  a_done_single: assert property (conversion_done |=> !conversion_done)
    else $error("done too long");
  a_done_after_conv: assert property (conversion_done |-> $past(outer_path_connect))
    else $error("done without conversion");
  a_cap_off_conv: assert property (conversion_done |-> !$past(extra_cap_connect))
    else $error("extra cap in conversion");
  a_strobe_done: assert property (compute_strobe |->
    conversion_done || $past(conversion_done)) else $error("stray compute");
endmodule
bind cvd_precharge_guard_sequencer cvd_seq_monitor u_mon (.clock(clock), .sys_rst(sys_rst),
  .read(read), .write(write), .waitrequest(waitrequest), .hold_to_supply(hold_to_supply),
  .hold_to_ground(hold_to_ground), .outer_path_connect(outer_path_connect),
  .pin_drive_out(pin_drive_out), .pin_drive_oe(pin_drive_oe), .extra_cap_connect(extra_cap_connect),
  .guard_out_a(guard_out_a), .guard_out_b(guard_out_b), .conversion_done(conversion_done),
  .compute_strobe(compute_strobe));
`default_nettype wire

// [test/tb_top.sv]
// testbench: register bus, stage sequencing, pin override and guards
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import cvd_seq_pkg::*;
  // ****************
  // signals
  // ****************
  logic clock = 0, sys_rst = 1, read = 0, write = 0, rc_osc_tick = 0;
  logic special_trigger = 0, restart_req = 0, threshold_event = 0;
  logic [3:0] address = 0, byteenable = 4'hF;
  logic [31:0] writedata = 0, readdata, q;
  logic waitrequest, hold_to_supply, hold_to_ground, outer_path_connect, pin_drive_out, pin_drive_oe;
  logic extra_cap_connect, guard_out_a, guard_out_b, conversion_done, compute_strobe;
  logic [7:0] extra_cap_sel, c0;
  logic [9:0] adc_data, v;
  logic hs, po, poe, gb, ga_acq;
  int errors = 0, compares = 0, pre_n, dones, strobes, p, a, d, n2, node_e = 0, rc_cnt = 0;
  int seed = 32'he49ed131;
  logic [3:0] ix [5] = '{IDX_CTRL0, IDX_CTRL1, IDX_PRE, IDX_ACQ, 4'hF};
  cvd_precharge_guard_sequencer uut (.*);
  sensor_model sm (.clock(clock), .pin_drive_out(pin_drive_out), .pin_drive_oe(pin_drive_oe),
    .hold_to_supply(hold_to_supply), .hold_to_ground(hold_to_ground),
    .outer_path_connect(outer_path_connect), .adc_data(adc_data));
  initial forever #2 clock = ~clock;
  // oscillator stand-in: one rising edge every six clocks
  always @(posedge clock) begin
    rc_cnt <= (rc_cnt + 1) % 3;
    if (rc_cnt == 2) rc_osc_tick <= ~rc_osc_tick;
  end
  // stage observer, sampled mid-cycle where outputs are settled
  always @(negedge clock) begin
    if (hold_to_supply || hold_to_ground) begin
      pre_n++;
      hs = hold_to_supply;
      po = pin_drive_out;
      poe = pin_drive_oe;
      gb = guard_out_b;
    end
    if (outer_path_connect) ga_acq = guard_out_a;
    dones += conversion_done;
    strobes += compute_strobe;
  end
  // ****************
  // tasks
  // ****************
  task automatic finish_test();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk_pin(string nm, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic chk_reg(string nm, logic [31:0] e, logic [31:0] g);
    chk_pin(nm, e, g);
  endtask
  // request held until waitrequest is low at a rising edge
  task automatic bus(logic [3:0] ad, logic w, logic [7:0] dt);
    int n;
    n = 0;
    address <= ad;
    writedata <= {24'h0, dt};
    write <= w;
    read <= !w;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 64);
    if (waitrequest !== 1'b0) begin
      errors++;
      finish_test();
    end
    q = readdata;
    write <= 0;
    read <= 0;
    @(posedge clock);
  endtask
  task automatic wdone(int t);
    int n;
    for (n = 0; n < 3000 && dones < t; n++) @(negedge clock);
    if (dones < t) begin
      errors++;
      finish_test();
    end
    @(posedge clock);
  endtask
  task automatic start(logic [7:0] c);
    pre_n = 0;
    dones = 0;
    bus(IDX_CTRL0, 1, c);
  endtask
  // ****************
  // sequence
  // ****************
  initial begin
    repeat (8) @(posedge clock);
    sys_rst <= 0;
    @(posedge clock);
    bus(4'hF, 1, 8'hAA);
    for (int i = 0; i < 5; i++) begin
      bus(ix[i], 0, 0);
      chk_reg("reset_val", 0, q[7:0]);
    end
    bus(IDX_CTRL1, 1, 8'hFF);
    bus(IDX_CTRL1, 0, 0);
    chk_reg("ctrl1_bits", 8'hE3, q[7:0]);
    bus(IDX_CAP, 1, 8'h05);
    chk_pin("cap_sel", 8'h05, extra_cap_sel);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      p = 1 + $unsigned($random(seed)) % 8;
      a = 1 + $unsigned($random(seed)) % 8;
      d = (i == 7) ? 2 : 0;
      bus(IDX_CLKDIV, 1, d[7:0]);
      bus(IDX_PRE, 1, p[7:0]);
      bus(IDX_ACQ, 1, a[7:0]);
      bus(IDX_CTRL1, 1, {i[0], 1'b0, i[2], 3'b0, i[1], 1'b0});
      c0 = {1'b1, 2'b0, i == 6, 1'b0, i[0] ^ i[2], 1'b0, 1'b1};
      start(c0);
      bus(IDX_CTRL0, 0, 0);
      chk_reg("busy", c0, q[7:0]);
      wdone(1);
      if (i == 6) chk_pin("pre_rc", 1, pre_n >= p * 6 - 6 && pre_n <= p * 6 + 6);
      else if (d == 0) chk_pin("pre_len", p, pre_n);
      else chk_pin("pre_div", 1, pre_n <= p * (d + 1) && pre_n >= p * (d + 1) - d);
      chk_pin("hold_sup", !i[0], hs);
      chk_pin("pin_oe", !i[1], poe);
      if (!i[1]) chk_pin("pin_lvl", i[0], po);
      chk_pin("grd_b", i[2], gb);
      chk_pin("grd_a", !i[2], ga_acq);
      if (!i[1]) node_e = i[0];
      v = (i[0] ? 10'h000 : 10'h0FF) + (node_e ? 10'h2FF : 10'h000);
      bus(IDX_CTRL0, 0, 0);
      chk_reg("go_clear", c0 & 8'hFE, q[7:0]);
      bus(IDX_RESULT, 0, 0);
      chk_reg("result", c0[2] ? {6'h0, v} : {v, 6'h0}, q[15:0]);
    end
    $display("test stages done");
    bus(IDX_CLKDIV, 1, 0);
    bus(IDX_PRE, 1, 3);
    bus(IDX_ACQ, 1, 0);
    bus(IDX_STATUS, 1, 8'h03);
    start(8'h81);
    for (n2 = 0; n2 < 100 && outer_path_connect !== 1'b1; n2++) @(posedge clock);
    repeat (40) @(posedge clock);
    chk_pin("acq_max", 1, outer_path_connect);
    bus(IDX_CTRL0, 1, 8'h80);
    repeat (20) @(posedge clock);
    chk_pin("abort_done", 0, dones);
    bus(IDX_STATUS, 0, 0);
    chk_reg("abort_flag", 0, q[0]);
    bus(IDX_PRE, 1, 0);
    start(8'h81);
    wdone(1);
    chk_pin("no_pre", 0, pre_n);
    $display("test abort done");
    start(8'h01);
    bus(IDX_CTRL0, 0, 0);
    chk_reg("off_go", 0, q[7:0]);
    special_trigger <= 1;
    @(posedge clock);
    special_trigger <= 0;
    repeat (20) @(posedge clock);
    chk_pin("off_trig", 0, dones);
    bus(IDX_PRE, 1, p[7:0]);
    for (int k = 0; k < 2; k++) begin
      start(8'h80);
      if (k == 1) restart_req <= 1;
      else special_trigger <= 1;
      @(posedge clock);
      restart_req <= 0;
      special_trigger <= 0;
      wdone(1);
      chk_pin("trig_pre", p, pre_n);
    end
    $display("test triggers done");
    bus(IDX_MISC, 1, 8'h01);
    start(8'hC1);
    wdone(2);
    threshold_event <= 1;
    @(posedge clock);
    threshold_event <= 0;
    wdone(3);
    bus(IDX_CTRL0, 0, 0);
    chk_reg("soi_stop", 8'hC0, q[7:0]);
    n2 = dones;
    repeat (300) @(posedge clock);
    chk_pin("soi_idle", n2, dones);
    $display("test retrigger done");
    bus(IDX_MISC, 1, 0);
    bus(IDX_CTRL1, 1, 8'h61);
    strobes = 0;
    for (int k = 0; k < 4; k++) begin
      start(8'h81);
      wdone(1);
      chk_pin("ds_grd_b", !k[0], gb);
      chk_pin("ds_hold", !k[0], hs);
      chk_pin("ds_grd_a", k[0], ga_acq);
    end
    repeat (4) @(posedge clock);
    chk_pin("pairs", 2, strobes);
    $display("test double sample done");
    finish_test();
  end
endmodule
`default_nettype wire
